// file: design/cac_params.svh
// constants for the counter array capture/compare block
`ifndef CAC_PARAMS_SVH
`define CAC_PARAMS_SVH
// ----------------------------------------
// mode bit positions in the channel mode byte
// ----------------------------------------
`define CAC_MODE_WIDE 7
`define CAC_MODE_CMP 6
`define CAC_MODE_RISE 5
`define CAC_MODE_FALL 4
`define CAC_MODE_MAT 3
`define CAC_MODE_FLIP 2
`define CAC_MODE_PULSE 1
`define CAC_MODE_IRQ 0
// ----------------------------------------
// cycle length codes and timebase codes
// ----------------------------------------
`define CAC_CYCLE_LENGTH_SELECT_8 2'h0
`define CAC_CYCLE_LENGTH_SELECT_9 2'h1
`define CAC_CYCLE_LENGTH_SELECT_10 2'h2
`define CAC_CYCLE_LENGTH_SELECT_11 2'h3
`define CAC_TB_DIV12 3'h0
`define CAC_TB_DIV4 3'h1
`define CAC_TB_TMR 3'h2
`define CAC_TB_EXT 3'h3
`define CAC_TB_SYS 3'h4
`define CAC_TB_OSC8 3'h5
`define CAC_DIV12_LAST 4'hb
`define CAC_DIV4_LAST 2'h3
`define CAC_DIV8_LAST 3'h7
`endif

// file: design/cac_pkg.sv
// types for the counter array capture/compare block
package cac_pkg;
  // ----------------------------------------
  // channel operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    CAC_IDLE = 3'b000,
    CAC_CAPTURE = 3'b001,
    CAC_TIMER = 3'b010,
    CAC_TOGGLE = 3'b011,
    CAC_FREQ = 3'b100,
    CAC_PWM_N = 3'b101,
    CAC_PWM_16 = 3'b110
  } cac_mode_t;
endpackage

// file: design/cac_channel.sv
// one capture/compare channel of the counter array
`timescale 1ns/1ns
`default_nettype none
`include "cac_params.svh"
module cac_channel (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic [15:0] count,
  input wire logic [7:0] mode,
  input wire logic [1:0] cycle_length_select,
  input wire logic reload_view_select,
  input wire logic low_wr,
  input wire logic high_wr,
  input wire logic [7:0] wr_data,
  input wire logic pin_rise,
  input wire logic pin_fall,
  output logic [7:0] channel_compare_low,
  output logic [7:0] channel_compare_high,
  output logic cmp_en,
  output logic channel_pin_out,
  output logic event_set
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] word_q;
  logic [15:0] reload_q;
  logic pin_q;
  logic cmp_q;
  cac_pkg::cac_mode_t md;
  logic [15:0] nmask;
  logic full_match, low_match, n_match, n_ovf, low_ovf;

  // mode decode from the mode byte
  always_comb begin
    if (mode[`CAC_MODE_RISE] || mode[`CAC_MODE_FALL]) begin
      md = cac_pkg::CAC_CAPTURE;
    end else if (mode[`CAC_MODE_PULSE] && mode[`CAC_MODE_WIDE]) begin
      md = cac_pkg::CAC_PWM_16;
    end else if (mode[`CAC_MODE_PULSE] && mode[`CAC_MODE_FLIP]) begin
      md = cac_pkg::CAC_FREQ;
    end else if (mode[`CAC_MODE_PULSE]) begin
      md = cac_pkg::CAC_PWM_N;
    end else if (mode[`CAC_MODE_FLIP]) begin
      md = cac_pkg::CAC_TOGGLE;
    end else if (mode[`CAC_MODE_MAT]) begin
      md = cac_pkg::CAC_TIMER;
    end else begin
      md = cac_pkg::CAC_IDLE;
    end
  end

  // shared cycle length gives the low-bit mask for n-bit pwm
  always_comb begin
    case (cycle_length_select)
      `CAC_CYCLE_LENGTH_SELECT_9: nmask = 16'h01ff;
      `CAC_CYCLE_LENGTH_SELECT_10: nmask = 16'h03ff;
      `CAC_CYCLE_LENGTH_SELECT_11: nmask = 16'h07ff;
      default: nmask = 16'h00ff;
    endcase
  end

  assign full_match = (count == word_q);
  assign low_match = (count[7:0] == word_q[7:0]);
  assign n_match = ((count & nmask) == (word_q & nmask));
  // the tick moves the low n bits from all ones to zero
  assign n_ovf = ((count & nmask) == nmask);
  assign low_ovf = (count[7:0] == 8'hff);
  assign cmp_en = cmp_q;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cmp_q <= 1'b0;
    end else if (high_wr && !reload_view_select) begin
      cmp_q <= 1'b1;
    end else if (low_wr && !reload_view_select) begin
      cmp_q <= 1'b0;
    end else if (high_wr) begin
      cmp_q <= 1'b1;
    end else if (low_wr) begin
      cmp_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reload_q <= 16'h0000;
    end else if (reload_view_select && low_wr) begin
      reload_q[7:0] <= wr_data;
    end else if (reload_view_select && high_wr) begin
      reload_q[15:8] <= wr_data;
    end
  end

  // capture/compare word: software writes win over hardware updates
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      word_q <= 16'h0000;
    end else if (!reload_view_select && low_wr) begin
      word_q[7:0] <= wr_data;
    end else if (!reload_view_select && high_wr) begin
      word_q[15:8] <= wr_data;
    end else if (md == cac_pkg::CAC_CAPTURE &&
                 ((mode[`CAC_MODE_RISE] && pin_rise) || (mode[`CAC_MODE_FALL] && pin_fall))) begin
      word_q <= count;
    end else if (tick && cmp_q) begin
      if (md == cac_pkg::CAC_FREQ && low_match) begin
        // advance low byte by half period
        word_q[7:0] <= word_q[7:0] + word_q[15:8];
      end else if (md == cac_pkg::CAC_PWM_N && cycle_length_select == `CAC_CYCLE_LENGTH_SELECT_8 && low_ovf) begin
        word_q[7:0] <= word_q[15:8];
      end else if (md == cac_pkg::CAC_PWM_N && cycle_length_select != `CAC_CYCLE_LENGTH_SELECT_8 && n_ovf) begin
        word_q <= reload_q;
      end
    end
  end

  // pin output per mode on counter ticks; the n-bit and 16-bit pwm modes force it low on any clock while cmp off
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_q <= 1'b0;
    end else if ((md == cac_pkg::CAC_PWM_N || md == cac_pkg::CAC_PWM_16) && !cmp_q) begin
      pin_q <= 1'b0;
    end else if (tick && cmp_q) begin
      case (md)
        // toggle on full match; held while cmp off
        cac_pkg::CAC_TOGGLE: if (full_match) pin_q <= ~pin_q;
        // zero high byte wraps to a full 256 step
        cac_pkg::CAC_FREQ: if (low_match) pin_q <= ~pin_q;
        cac_pkg::CAC_PWM_N: begin
          if (cycle_length_select == `CAC_CYCLE_LENGTH_SELECT_8) begin
            // set on low byte match, clear on wrap
            if (low_ovf) pin_q <= 1'b0;
            else if (low_match) pin_q <= 1'b1;
          end else begin
            // set on n-bit match, clear on bit n overflow
            if (n_ovf) pin_q <= 1'b0;
            else if (n_match) pin_q <= 1'b1;
          end
        end
        // set on full match, clear on 16-bit overflow
        cac_pkg::CAC_PWM_16: begin
          if (count == 16'hffff) pin_q <= 1'b0;
          else if (full_match) pin_q <= 1'b1;
        end
        default: pin_q <= pin_q;
      endcase
    end
  end
  assign channel_pin_out = pin_q;

  // event pulse: captures and matches
  always_comb begin
    event_set = 1'b0;
    if (md == cac_pkg::CAC_CAPTURE) begin
      event_set = (mode[`CAC_MODE_RISE] && pin_rise) || (mode[`CAC_MODE_FALL] && pin_fall);
    end else if (tick && cmp_q && mode[`CAC_MODE_MAT]) begin
      case (md)
        // timer equality; freq uses full word
        cac_pkg::CAC_TIMER, cac_pkg::CAC_TOGGLE, cac_pkg::CAC_FREQ,
        cac_pkg::CAC_PWM_16: event_set = full_match;
        // 8-bit rising match; n-bit rising match
        cac_pkg::CAC_PWM_N: event_set = (cycle_length_select == `CAC_CYCLE_LENGTH_SELECT_8) ? low_match : n_match;
        default: event_set = 1'b0;
      endcase
    end
  end
  assign channel_compare_low = reload_view_select ? reload_q[7:0] : word_q[7:0];
  assign channel_compare_high = reload_view_select ? reload_q[15:8] : word_q[15:8];
endmodule
`default_nettype wire

// file: design/cac_top.sv
// counter array with its capture/compare channels
`timescale 1ns/1ns
`default_nettype none
`include "cac_params.svh"
module cac_top #(
  parameter int CHANNELS = 6
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic counter_run,
  input wire logic [2:0] timebase_select,
  input wire logic timer_overflow,
  input wire logic ext_count_pin,
  input wire logic ext_osc_clk,
  input wire logic [1:0] cycle_length_select,
  input wire logic reload_view_select,
  input wire logic counter_irq_enable,
  input wire logic short_overflow_irq_enable,
  input wire logic counter_overflow_clear,
  input wire logic short_overflow_clear,
  input wire logic [CHANNELS*8-1:0] channel_mode_register,
  input wire logic [CHANNELS-1:0] low_write,
  input wire logic [CHANNELS-1:0] high_write,
  input wire logic [7:0] write_data,
  input wire logic [CHANNELS-1:0] event_flag_clear,
  input wire logic [CHANNELS-1:0] channel_pin_in,
  output logic [CHANNELS-1:0] channel_pin_out,
  output logic [CHANNELS*8-1:0] channel_compare_low,
  output logic [CHANNELS*8-1:0] channel_compare_high,
  output logic [CHANNELS-1:0] compare_enable,
  output logic [CHANNELS-1:0] channel_event_flag,
  output logic counter_overflow_flag,
  output logic short_overflow_flag,
  output logic [7:0] counter_low_byte,
  output logic [7:0] counter_high_byte,
  output logic counter_array_irq
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [CHANNELS-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
  logic [2:0] ext_s_q, osc_s_q;
  logic ext_lvl_q, osc_lvl_q;

  // three flops; a change counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_lvl_q <= '0;
    end else begin
      pin_s1_q <= channel_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_lvl_q <= (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q | pin_s3_q));
    end
  end

  // same filtering for the external count pin and oscillator
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ext_s_q <= 3'h0;
      osc_s_q <= 3'h0;
      ext_lvl_q <= 1'b0;
      osc_lvl_q <= 1'b0;
    end else begin
      ext_s_q <= {ext_s_q[1:0], ext_count_pin};
      osc_s_q <= {osc_s_q[1:0], ext_osc_clk};
      if (ext_s_q[1] == ext_s_q[2]) ext_lvl_q <= ext_s_q[2];
      if (osc_s_q[1] == osc_s_q[2]) osc_lvl_q <= osc_s_q[2];
    end
  end

  // filtered pin edges for capture
  logic [CHANNELS-1:0] lvl_new, pin_rise, pin_fall;
  assign lvl_new = (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q | pin_s3_q));
  assign pin_rise = lvl_new & ~pin_lvl_q;
  assign pin_fall = ~lvl_new & pin_lvl_q;

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  logic [3:0] div_q;
  logic [2:0] osc_div_q;
  logic ext_prev_q, osc_prev_q;
  logic tick;

  // prescale counters, free running
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      div_q <= 4'h0;
      osc_div_q <= 3'h0;
      ext_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      div_q <= (div_q == `CAC_DIV12_LAST) ? 4'h0 : div_q + 4'h1;
      ext_prev_q <= ext_lvl_q;
      osc_prev_q <= osc_lvl_q;
      if (osc_lvl_q && !osc_prev_q) osc_div_q <= osc_div_q + 3'h1;
    end
  end

  always_comb begin
    case (timebase_select)
      `CAC_TB_DIV12: tick = (div_q == `CAC_DIV12_LAST);
      `CAC_TB_DIV4: tick = (div_q[1:0] == `CAC_DIV4_LAST);
      `CAC_TB_TMR: tick = timer_overflow;
      `CAC_TB_EXT: tick = ext_prev_q && !ext_lvl_q;
      `CAC_TB_SYS: tick = 1'b1;
      `CAC_TB_OSC8: tick = osc_lvl_q && !osc_prev_q && (osc_div_q == `CAC_DIV8_LAST);
      default: tick = 1'b0;
    endcase
    tick = tick && counter_run;
  end

  // ----------------------------------------
  // counter and overflow flags
  // ----------------------------------------
  logic [15:0] count_q;
  logic cf_q, short_overflow_flag_q;
  logic short_ovf;

  // counter advances on ticks only
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      count_q <= 16'h0000;
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // short overflow out of bit 8, 9, 10 or 11
  always_comb begin
    case (cycle_length_select)
      `CAC_CYCLE_LENGTH_SELECT_9: short_ovf = (count_q[8:0] == 9'h1ff);
      `CAC_CYCLE_LENGTH_SELECT_10: short_ovf = (count_q[9:0] == 10'h3ff);
      `CAC_CYCLE_LENGTH_SELECT_11: short_ovf = (count_q[10:0] == 11'h7ff);
      default: short_ovf = (count_q[7:0] == 8'hff);
    endcase
  end

  // flags set on trigger; set beats clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cf_q <= 1'b0;
      short_overflow_flag_q <= 1'b0;
    end else begin
      if (tick && count_q == 16'hffff) cf_q <= 1'b1;
      else if (counter_overflow_clear) cf_q <= 1'b0;
      if (tick && short_ovf) short_overflow_flag_q <= 1'b1;
      else if (short_overflow_clear) short_overflow_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // channels
  // ----------------------------------------
  logic [CHANNELS-1:0] ev_set;
  logic [CHANNELS-1:0] ccf_q;
  logic [CHANNELS-1:0] irq_en;

  // one shared cycle length feeds all channels
  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    cac_channel u_ch (
      .core_clk(core_clk),
      .rstn(rstn),
      .tick(tick),
      .count(count_q),
      .mode(channel_mode_register[i*8 +: 8]),
      .cycle_length_select(cycle_length_select),
      .reload_view_select(reload_view_select),
      .low_wr(low_write[i]),
      .high_wr(high_write[i]),
      .wr_data(write_data),
      .pin_rise(pin_rise[i]),
      .pin_fall(pin_fall[i]),
      .channel_compare_low(channel_compare_low[i*8 +: 8]),
      .channel_compare_high(channel_compare_high[i*8 +: 8]),
      .cmp_en(compare_enable[i]),
      .channel_pin_out(channel_pin_out[i]),
      .event_set(ev_set[i])
    );
    assign irq_en[i] = channel_mode_register[i*8 + `CAC_MODE_IRQ];
  end

  // event flags: hardware sets, software clears, set wins
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ccf_q <= '0;
    end else begin
      ccf_q <= ev_set | (ccf_q & ~event_flag_clear);
    end
  end

  // interrupt gated by each flag's own enable
  assign counter_array_irq = |(ccf_q & irq_en) | (cf_q & counter_irq_enable) |
                             (short_overflow_flag_q & short_overflow_irq_enable);
  assign channel_event_flag = ccf_q;
  assign counter_overflow_flag = cf_q;
  assign short_overflow_flag = short_overflow_flag_q;
  assign counter_low_byte = count_q[7:0];
  assign counter_high_byte = count_q[15:8];
endmodule
`default_nettype wire

// file: verification/cac_pin_src.sv
// external signal source model driving one channel pin
`timescale 1ns/1ns
`default_nettype none
module cac_pin_src (
  input wire logic core_clk,
  output logic pin
);
  // pin idles low until the bench asks for a level
  initial pin = 1'b0;
  // each level held two clocks or more
  task automatic drive(input logic lvl, input int hold);
    @(posedge core_clk);
    #1 pin = lvl;
    repeat (hold < 2 ? 2 : hold) @(posedge core_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// file: verification/cac_top_monitor.sv
// assertion checker on the capture/compare top ports
`timescale 1ns/1ns
`default_nettype none
module cac_monitor #(
  parameter int CHANNELS = 6
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic counter_run,
  input wire logic [2:0] timebase_select,
  input wire logic [1:0] cycle_length_select,
  input wire logic reload_view_select,
  input wire logic counter_irq_enable,
  input wire logic short_overflow_irq_enable,
  input wire logic [CHANNELS*8-1:0] channel_mode_register,
  input wire logic [CHANNELS-1:0] low_write,
  input wire logic [CHANNELS-1:0] high_write,
  input wire logic [CHANNELS-1:0] event_flag_clear,
  input wire logic [CHANNELS-1:0] channel_pin_out,
  input wire logic [CHANNELS*8-1:0] channel_compare_low,
  input wire logic [CHANNELS*8-1:0] channel_compare_high,
  input wire logic [CHANNELS-1:0] compare_enable,
  input wire logic [CHANNELS-1:0] channel_event_flag,
  input wire logic counter_overflow_flag,
  input wire logic short_overflow_flag,
  input wire logic [7:0] counter_low_byte,
  input wire logic [7:0] counter_high_byte,
  input wire logic counter_array_irq
);
  // ----------------------------------------
  // channel 0 decode and helpers
  // ----------------------------------------
  logic [CHANNELS-1:0] ien;
  logic [7:0] m;
  logic run, nowr, tmr0, tog0, pwm0;
  logic [15:0] cnt;
  logic [10:0] nmask;
  // per channel interrupt enable bits
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      ien[i] = channel_mode_register[8*i];
    end
  end
  // only the system clock timebase is judged, other rates tick unevenly
  assign m = channel_mode_register[7:0];
  assign run = counter_run && timebase_select == 3'h4;
  assign nowr = !low_write[0] && !high_write[0];
  assign tmr0 = !m[7] && m[5:1] == 5'h04;
  assign tog0 = m[5:1] == 5'h06;
  assign pwm0 = m[5:4] == 2'h0 && m[2:1] == 2'h1;
  assign cnt = {counter_high_byte, counter_low_byte};
  assign nmask = 11'h7ff >> (2'h3 - cycle_length_select);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_low_write_clears: assert property (low_write[0] && !high_write[0] |=> !compare_enable[0])
    else $error("compare enable kept after low byte write");
  a_high_write_sets: assert property (high_write[0] && !low_write[0] |=> compare_enable[0])
    else $error("compare enable not set by high byte write");
  a_flag_sticky: assert property (channel_event_flag[0] && !event_flag_clear[0] |=> channel_event_flag[0])
    else $error("event flag dropped without clear");
  a_irq_gating: assert property (counter_array_irq == (|(channel_event_flag & ien)
    || (counter_irq_enable && counter_overflow_flag)
    || (short_overflow_irq_enable && short_overflow_flag)))
    else $error("interrupt does not follow enabled flags");
  a_timer_match_flag: assert property (run && tmr0 && compare_enable[0] && nowr
    && !reload_view_select && cnt == {channel_compare_high[7:0], channel_compare_low[7:0]}
    |=> channel_event_flag[0])
    else $error("timer match did not set event flag");
  a_short_ovf_set: assert property (run && (cnt[10:0] & nmask) == nmask |=> short_overflow_flag)
    else $error("short overflow flag missing");
  a_pwm8_reload: assert property (run && pwm0 && !m[7] && compare_enable[0] && nowr
    && cycle_length_select == 2'h0 && !reload_view_select && counter_low_byte == 8'hff
    |=> channel_compare_low[7:0] == $past(channel_compare_high[7:0]))
    else $error("low byte not reloaded on wrap");
  a_pwm_off_low: assert property ((pwm0 && !compare_enable[0])[*2] |-> !channel_pin_out[0])
    else $error("pulse output high with compare off");
  a_toggle_hold: assert property ((tog0 && !compare_enable[0])[*2] |-> $stable(channel_pin_out[0]))
    else $error("toggle pin moved with compare off");
  // main scenarios reached
  c_capture: cover property (channel_event_flag[0] && m[5:4] != 2'h0);
  c_pwm_rise: cover property ($rose(channel_pin_out[0]) && pwm0);
  c_short_ovf: cover property ($rose(short_overflow_flag));
endmodule
bind cac_top cac_monitor #(.CHANNELS(CHANNELS)) u_mon (.*);
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the capture/compare top
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk = 1'b0, rstn = 1'b0, counter_run = 1'b0;
  logic [2:0] timebase_select = 3'h4;
  logic timer_overflow = 1'b0, ext_count_pin = 1'b0, ext_osc_clk = 1'b0;
  logic [1:0] cycle_length_select = 2'h0;
  logic reload_view_select = 1'b0, counter_irq_enable = 1'b0;
  logic short_overflow_irq_enable = 1'b0;
  logic counter_overflow_clear = 1'b0, short_overflow_clear = 1'b0;
  logic [15:0] channel_mode_register = 16'h0;
  logic [1:0] low_write = 2'h0, high_write = 2'h0, event_flag_clear = 2'h0;
  logic [7:0] write_data = 8'h0;
  logic [15:0] exp_cnt;
  wire p0;
  wire [1:0] channel_pin_in = {1'b0, p0};
  wire [1:0] channel_pin_out, compare_enable, channel_event_flag;
  wire [15:0] channel_compare_low, channel_compare_high;
  wire counter_overflow_flag, short_overflow_flag, counter_array_irq;
  wire [7:0] counter_low_byte, counter_high_byte;
  wire [15:0] word0 = {channel_compare_high[7:0], channel_compare_low[7:0]};
  int mismatches = 0;
  int n_compared = 0;
  cac_top #(.CHANNELS(2)) uut (.*);
  cac_pin_src src (.core_clk(core_clk), .pin(p0));
  // clock and reference count of counter clocks
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (!rstn) exp_cnt <= 16'h0;
    else if (counter_run && timebase_select == 3'h4) exp_cnt <= exp_cnt + 16'h1;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // low byte first, then high byte, watching compare enable
  task automatic wr(input logic [15:0] w);
    write_data = w[7:0];
    low_write = 2'h1;
    tick(1);
    chk(compare_enable[0], 1'b0);
    low_write = 2'h0;
    write_data = w[15:8];
    high_write = 2'h1;
    tick(1);
    high_write = 2'h0;
    chk(compare_enable[0], 1'b1);
  endtask
  task automatic clr();
    event_flag_clear = 2'h1;
    short_overflow_clear = 1'b1;
    counter_overflow_clear = 1'b1;
    tick(1);
    event_flag_clear = 2'h0;
    short_overflow_clear = 1'b0;
    counter_overflow_clear = 1'b0;
  endtask
  // bounded wait, n is the cycles spent
  task automatic wait_pin(input logic lvl, input int lim, output int n);
    n = 0;
    while (channel_pin_out[0] !== lvl && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_capture();
    for (int i = 1; i < 4; i++) begin
      channel_mode_register[7:0] = {2'h0, i[1:0], 4'h1};
      counter_run = 1'b1;
      tick(3 + i);
      counter_run = 1'b0;
      chk({counter_high_byte, counter_low_byte}, exp_cnt);
      src.drive(1'b1, 8);
      chk(channel_event_flag[0], i[1]);
      chk(counter_array_irq, i[1]);
      if (i[1]) chk(word0, exp_cnt);
      clr();
      counter_run = 1'b1;
      tick(2);
      counter_run = 1'b0;
      src.drive(1'b0, 8);
      chk(channel_event_flag[0], i[0]);
      if (i[0]) chk(word0, exp_cnt);
      clr();
    end
  endtask
  task automatic t_timer();
    logic [15:0] w;
    counter_run = 1'b1;
    for (int i = 0; i < 2; i++) begin
      channel_mode_register[7:0] = i ? 8'h0d : 8'h09;
      w = exp_cnt + 16'd30;
      wr(w);
      tick(28);
      chk(channel_event_flag[0], 1'b0);
      tick(1);
      // flag on full match, toggle only in toggle mode
      chk(channel_event_flag[0], 1'b1);
      chk(channel_pin_out[0], i[0]);
      clr();
      w = exp_cnt + 16'd20;
      wr(w);
      write_data = w[7:0];
      low_write = 2'h1;
      tick(1);
      low_write = 2'h0;
      tick(30);
      // compare off keeps pin, no flag
      chk(channel_pin_out[0], i[0]);
      chk(channel_event_flag[0], 1'b0);
    end
  endtask
  task automatic t_freq();
    int n;
    channel_mode_register[7:0] = 8'h06;
    for (int i = 0; i < 2; i++) begin
      wr({i ? 8'h00 : 8'h04, exp_cnt[7:0] + 8'h05});
      wait_pin(~channel_pin_out[0], 300, n);
      wait_pin(~channel_pin_out[0], 300, n);
      // half period from the high byte
      chk(n[15:0], i ? 16'd256 : 16'd4);
    end
  endtask
  task automatic t_pwm(input int k);
    int hi;
    int lo;
    logic [15:0] w;
    w = k ? (16'h100 << k) - 16'd100 : 16'hc0c0;
    cycle_length_select = k[1:0];
    channel_mode_register[7:0] = k ? 8'h02 : 8'h0a;
    short_overflow_irq_enable = 1'b1;
    reload_view_select = k != 0;
    wr(w);
    // reload word seen through the shared bytes
    if (k) chk(word0, w);
    reload_view_select = 1'b0;
    // old word runs one period; its overflow loads the new word
    wait_pin(1'b1, 2100, hi);
    wait_pin(1'b0, 2100, hi);
    wait_pin(1'b1, 2100, lo);
    wait_pin(1'b0, 2100, hi);
    chk(hi[15:0], k ? 16'd99 : 16'd63);
    chk(16'(hi + lo), 16'h100 << k);
    chk(short_overflow_flag, 1'b1);
    chk(counter_array_irq, 1'b1);
    if (k == 0) chk(channel_event_flag[0], 1'b1);
    // flag still set but its enable off
    short_overflow_irq_enable = 1'b0;
    tick(1);
    chk(counter_array_irq, 1'b0);
    clr();
    write_data = w[7:0];
    low_write = 2'h1;
    tick(1);
    low_write = 2'h0;
    tick(300);
    chk(channel_pin_out[0], 1'b0);
  endtask
  // 16-bit pulse rise and the divided timebases
  task automatic t_wide();
    logic [15:0] c;
    channel_mode_register[7:0] = 8'h8a;
    wr(exp_cnt + 16'd10);
    tick(8);
    chk(channel_pin_out[0], 1'b0);
    chk(channel_event_flag[0], 1'b0);
    tick(1);
    // pin rises and flags on the full match
    chk(channel_pin_out[0], 1'b1);
    chk(channel_event_flag[0], 1'b1);
    // clock by 4 and by 12
    c = {counter_high_byte, counter_low_byte};
    timebase_select = 3'h1;
    tick(40);
    chk({counter_high_byte, counter_low_byte} - c, 16'd10);
    c = {counter_high_byte, counter_low_byte};
    timebase_select = 3'h0;
    tick(48);
    chk({counter_high_byte, counter_low_byte} - c, 16'd4);
    timebase_select = 3'h4;
  endtask
  // ----------------------------------------
  // verdict, main sequence, watchdog
  // ----------------------------------------
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    tick(4);
    rstn = 1'b1;
    t_capture();
    t_timer();
    t_freq();
    for (int k = 0; k < 4; k++) t_pwm(k);
    t_wide();
    close_out();
  end
  // about three and a half times the expected run length
  initial begin
    #1500000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
